// *** inc/bdaf_defs.svh ***
`ifndef BDAF_DEFS_SVH
`define BDAF_DEFS_SVH
// register word indices; byte address is index times four
`define BDAF_IDX_TXLEN_LO    6'h00
`define BDAF_IDX_TXLEN_HI    6'h01
`define BDAF_IDX_RING_FIRST  6'h02
`define BDAF_IDX_RING_END    6'h03
`define BDAF_IDX_RING_BNDRY  6'h04
`define BDAF_IDX_RX_WRPAGE   6'h05
`define BDAF_IDX_LOCAL_LO    6'h06
`define BDAF_IDX_LOCAL_HI    6'h07
`define BDAF_IDX_RSTART_LO   6'h08
`define BDAF_IDX_RSTART_HI   6'h09
`define BDAF_IDX_RLEN_LO     6'h0A
`define BDAF_IDX_RLEN_HI     6'h0B
`define BDAF_IDX_RPTR_LO     6'h0C
`define BDAF_IDX_RPTR_HI     6'h0D
`define BDAF_IDX_CTRL        6'h0E
`define BDAF_IDX_STATUS      6'h0F
`define BDAF_IDX_STATION0    6'h10
`define BDAF_IDX_HASH0       6'h18
// control register bit positions
`define BDAF_CTRL_RSTART     0
`define BDAF_CTRL_RWORD      1
`define BDAF_CTRL_LSTART     2
`define BDAF_CTRL_PROMISC    3
// status register bit positions
`define BDAF_ST_RBUSY        0
`define BDAF_ST_LBUSY        1
`define BDAF_ST_LABORT       2
`define BDAF_ST_ACCEPT       3
`define BDAF_ST_GROUP        4
// crc generator seed and polynomial (msb-first, non-reflected shift form)
`define BDAF_CRC_SEED        32'hFFFFFFFF
`define BDAF_CRC_POLY        32'h04C11DB7
`define BDAF_DA_BITS         6'h30
`endif

// *** inc/bdaf_pkg.sv ***
package bdaf_pkg;
    // remote channel states
    typedef enum logic [2:0] {
        BDAF_R_IDLE = 3'b001,
        BDAF_R_REQ  = 3'b010,
        BDAF_R_WAIT = 3'b100
    } bdaf_rstate_t;
    // local receive channel states
    typedef enum logic [2:0] {
        BDAF_L_IDLE = 3'b001,
        BDAF_L_RUN  = 3'b010,
        BDAF_L_ABRT = 3'b100
    } bdaf_lstate_t;
endpackage

// *** hw/bdaf_top.sv ***
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bdaf_defs.svh"

module bdaf_top
    import bdaf_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             mem_req,
    output logic      [15:0] mem_addr,
    output logic             mem_word,
    input  wire logic        mem_ack,
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit,
    input  wire logic        rx_frame,
    input  wire logic        rx_byte_stb,
    input  wire logic        rx_error,
    output logic             addr_accept,
    output logic             addr_done,
    output logic             local_abort
);
    // =====================================================
    // state
    // =====================================================
    typedef struct packed {
        logic [15:0]  txlen;       // transmit byte count
        logic [7:0]   ring_first;  // ring start page
        logic [7:0]   ring_end;    // ring end page
        logic [7:0]   bndry;       // read boundary page
        logic [7:0]   wrpage;      // receive write page
        logic [15:0]  laddr;       // working local address
        logic [15:0]  rstart;      // remote start address
        logic [15:0]  rlen;        // remote programmed length
        logic [15:0]  raddr;       // working remote address
        logic [15:0]  rcnt;        // remaining remote bytes
        logic         rword;       // remote word mode
        logic         promisc;     // accept any physical address
        bdaf_rstate_t rst;         // remote channel state
        bdaf_lstate_t lst;         // local channel state
        logic [47:0]  station;     // station address bytes
        logic [63:0]  hash;        // group hash table
        logic [31:0]  crc;         // destination crc
        logic [5:0]   bitcnt;      // destination bits seen
        logic         dmatch;      // all bits matched so far
        logic         grp;         // individual/group flag
        logic [5:0]   hidx;        // latched hash index
        logic         accept;      // filter verdict
        logic         done;        // verdict pulse
        logic         wsel;        // data phase is write
        logic [5:0]   widx;        // data phase word index
        logic         dvalid;      // data phase pending
        logic [31:0]  rdata;       // read data register
    } bdaf_state_t;

    bdaf_state_t s_q;  // registered state
    bdaf_state_t s_d;  // next state

    // =====================================================
    // helpers
    // =====================================================
    // one crc step, msb-first register fed with each bit
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
        crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? `BDAF_CRC_POLY : 32'h00000000);
    endfunction

    // next page, wrapping from ring end back to ring start
    function automatic logic [7:0] page_next(input logic [7:0] p,
                                             input logic [7:0] last,
                                             input logic [7:0] first);
        logic [7:0] n;
        n = p + 8'h01;
        // end page is never entered
        page_next = (n == last) ? first : n;
    endfunction

    // =====================================================
    // synchronisers for pins from the serial receive path
    // =====================================================
    // five receive pins, one two-stage chain
    logic [4:0] sy1_q;  // first stage, read only by second
    logic [4:0] sy2_q;  // second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sy1_q <= 5'h00;
            sy2_q <= 5'h00;
        end else begin
            sy1_q <= {rx_error, rx_byte_stb, rx_frame, rx_bit, rx_bit_valid};
            sy2_q <= sy1_q;
        end
    end
    logic s_bv;    // synced bit valid level
    logic s_bit;   // synced bit
    logic s_fr;    // synced frame
    logic s_bs;    // synced byte strobe level
    logic s_err;   // synced receive error
    logic bv_p_q;  // previous bit valid
    logic bs_p_q;  // previous byte strobe
    always_comb begin
        {s_err, s_bs, s_fr, s_bit, s_bv} = sy2_q;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bv_p_q <= 1'b0;
            bs_p_q <= 1'b0;
        end else begin
            bv_p_q <= s_bv;
            bs_p_q <= s_bs;
        end
    end
    // rising edges only; pins idle low
    logic bit_ev;   // new serial bit
    logic byte_ev;  // one byte written to the ring
    always_comb begin
        bit_ev  = s_bv & ~bv_p_q;
        byte_ev = s_bs & ~bs_p_q;
    end

    // =====================================================
    // bus address phase
    // =====================================================
    logic       aphase;  // accepted transfer
    logic [5:0] aidx;    // word index
    logic       wr_en;   // write lands this cycle
    always_comb begin
        aphase = hsel & hready & htrans[1];
        aidx   = haddr[7:2];
        wr_en  = s_q.dvalid & s_q.wsel;
    end

    // =====================================================
    // next-state logic
    // =====================================================
    logic [7:0]  wb;      // write byte
    logic [15:0] step;    // remote step size
    logic [5:0]  di;      // destination bit index
    logic [47:0] smask;   // station bit under test
    always_comb begin
        s_d   = s_q;
        wb    = hwdata[7:0];
        step  = s_q.rword ? 16'h0002 : 16'h0001;
        di    = s_q.bitcnt;
        smask = 48'h000000000000;
        // one-cycle verdict pulse
        s_d.done = 1'b0;

        // register writes; byte lanes beyond the low one ignored
        if (wr_en) begin
            unique case (s_q.widx)
                `BDAF_IDX_TXLEN_LO:   s_d.txlen[7:0]  = wb;
                `BDAF_IDX_TXLEN_HI:   s_d.txlen[15:8] = wb;
                `BDAF_IDX_RING_FIRST: s_d.ring_first = wb;
                `BDAF_IDX_RING_END:   s_d.ring_end   = wb;
                `BDAF_IDX_RING_BNDRY: s_d.bndry      = wb;
                `BDAF_IDX_RX_WRPAGE:  s_d.wrpage     = wb;
                `BDAF_IDX_RSTART_LO:  s_d.rstart[7:0]  = wb;
                `BDAF_IDX_RSTART_HI:  s_d.rstart[15:8] = wb;
                `BDAF_IDX_RLEN_LO:    s_d.rlen[7:0]    = wb;
                `BDAF_IDX_RLEN_HI:    s_d.rlen[15:8]   = wb;
                `BDAF_IDX_CTRL: begin
                    s_d.rword   = wb[`BDAF_CTRL_RWORD];
                    s_d.promisc = wb[`BDAF_CTRL_PROMISC];
                    // start remote only when idle and a count exists
                    if (wb[`BDAF_CTRL_RSTART] && s_q.rst == BDAF_R_IDLE) begin
                        // zero count: no access
                        if (s_q.rlen != 16'h0000) begin
                            s_d.raddr = s_q.rstart;
                            s_d.rcnt  = s_q.rlen;
                            s_d.rst   = BDAF_R_REQ;
                        end
                    end
                    // local channel opens at the write page
                    if (wb[`BDAF_CTRL_LSTART]) begin
                        s_d.laddr = {s_q.wrpage, 8'h00};
                        s_d.lst   = BDAF_L_RUN;
                    end
                end
                default: begin
                    if (s_q.widx[5:3] == 3'b010 && s_q.widx[2:0] < 3'h6) begin
                        s_d.station[{s_q.widx[2:0], 3'b000} +: 8] = wb;
                    end else if (s_q.widx[5:3] == 3'b011) begin
                        s_d.hash[{s_q.widx[2:0], 3'b000} +: 8] = wb;
                    end
                end
            endcase
        end

        // remote channel: one memory access per grant
        unique case (s_q.rst)
            BDAF_R_IDLE: begin
                // parked until started
            end
            BDAF_R_REQ: begin
                if (mem_ack) begin
                    s_d.raddr = s_q.raddr + step;
                    // odd last byte in word mode drops to zero
                    s_d.rcnt = (s_q.rcnt < step) ? 16'h0000 : s_q.rcnt - step;
                    s_d.rst  = BDAF_R_WAIT;
                end
            end
            BDAF_R_WAIT: begin
                s_d.rst = (s_q.rcnt == 16'h0000) ? BDAF_R_IDLE : BDAF_R_REQ;
            end
        endcase

        // local receive channel, page linking and recovery
        unique case (s_q.lst)
            BDAF_L_IDLE: begin
                // parked until started
            end
            BDAF_L_RUN: begin
                if (s_err) begin
                    s_d.laddr = {s_q.wrpage, 8'h00};
                end else if (byte_ev) begin
                    if (s_q.laddr[7:0] == 8'hFF) begin
                        // linking to the next page
                        if (page_next(s_q.laddr[15:8], s_q.ring_end, s_q.ring_first)
                                == s_q.bndry) begin
                            s_d.lst = BDAF_L_ABRT;
                        end else begin
                            s_d.laddr = {page_next(s_q.laddr[15:8], s_q.ring_end,
                                                   s_q.ring_first), 8'h00};
                        end
                    end else begin
                        s_d.laddr = s_q.laddr + 16'h0001;
                    end
                end
            end
            BDAF_L_ABRT: begin
                // held until software restarts the channel
            end
        endcase

        // destination address filter
        if (!s_fr) begin
            s_d.bitcnt = 6'h00;
            s_d.crc    = `BDAF_CRC_SEED;
            s_d.dmatch = 1'b1;
        end else if (bit_ev && s_q.bitcnt < `BDAF_DA_BITS) begin
            smask[di] = 1'b1;
            s_d.crc    = crc_step(s_q.crc, s_bit);
            s_d.bitcnt = s_q.bitcnt + 6'h01;
            // station byte n bit k is destination bit 8n+k
            if (((s_q.station & smask) != 48'h000000000000) != s_bit) begin
                s_d.dmatch = 1'b0;
            end
            if (s_q.bitcnt == 6'h00) begin
                s_d.grp = s_bit;
            end
            if (s_q.bitcnt == `BDAF_DA_BITS - 6'h01) begin
                s_d.hidx = s_d.crc[31:26];
                s_d.done = 1'b1;
                if (s_q.grp) begin
                    s_d.accept = s_q.hash[s_d.crc[31:26]];
                end else begin
                    s_d.accept = s_d.dmatch | s_q.promisc;
                end
            end
        end

        // bus bookkeeping and read data
        // read word lands in the data phase
        s_d.dvalid = aphase;
        s_d.wsel   = hwrite;
        s_d.widx   = aidx;
        if (aphase && !hwrite) begin
            s_d.rdata = rd_mux(aidx);
        end
    end

    // read mux; unmapped words read zero
    function automatic logic [31:0] rd_mux(input logic [5:0] i);
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            `BDAF_IDX_TXLEN_LO:   v = s_q.txlen[7:0];
            `BDAF_IDX_TXLEN_HI:   v = s_q.txlen[15:8];
            `BDAF_IDX_RING_FIRST: v = s_q.ring_first;
            `BDAF_IDX_RING_END:   v = s_q.ring_end;
            `BDAF_IDX_RING_BNDRY: v = s_q.bndry;
            `BDAF_IDX_RX_WRPAGE:  v = s_q.wrpage;
            `BDAF_IDX_LOCAL_LO:   v = s_q.laddr[7:0];
            `BDAF_IDX_LOCAL_HI:   v = s_q.laddr[15:8];
            `BDAF_IDX_RSTART_LO:  v = s_q.rstart[7:0];
            `BDAF_IDX_RSTART_HI:  v = s_q.rstart[15:8];
            `BDAF_IDX_RLEN_LO:    v = s_q.rlen[7:0];
            `BDAF_IDX_RLEN_HI:    v = s_q.rlen[15:8];
            `BDAF_IDX_RPTR_LO:    v = s_q.raddr[7:0];
            `BDAF_IDX_RPTR_HI:    v = s_q.raddr[15:8];
            `BDAF_IDX_CTRL:       v = {4'h0, s_q.promisc, 1'b0, s_q.rword, 1'b0};
            `BDAF_IDX_STATUS:     v = {3'h0, s_q.grp, s_q.accept,
                                       s_q.lst == BDAF_L_ABRT, s_q.lst == BDAF_L_RUN,
                                       s_q.rst != BDAF_R_IDLE};
            default: begin
                if (i[5:3] == 3'b010 && i[2:0] < 3'h6) begin
                    v = s_q.station[{i[2:0], 3'b000} +: 8];
                end else if (i[5:3] == 3'b011) begin
                    v = s_q.hash[{i[2:0], 3'b000} +: 8];
                end
            end
        endcase
        rd_mux = {24'h000000, v};
    endfunction

    // =====================================================
    // state register
    // =====================================================
    // async assert, release on an edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q        <= '0;
            s_q.rst    <= BDAF_R_IDLE;
            s_q.lst    <= BDAF_L_IDLE;
            s_q.crc    <= `BDAF_CRC_SEED;
            s_q.dmatch <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // =====================================================
    // outputs
    // =====================================================
    // all outputs are flops, decodes of state flops, or constants
    always_comb begin
        hrdata      = s_q.rdata;
        hreadyout   = 1'b1;   // zero wait states
        hresp       = 1'b0;   // always okay
        mem_req     = (s_q.rst == BDAF_R_REQ);
        mem_addr    = s_q.raddr;
        mem_word    = s_q.rword;
        addr_accept = s_q.accept;
        addr_done   = s_q.done;
        local_abort = (s_q.lst == BDAF_L_ABRT);
    end
endmodule
`default_nettype wire

// *** tb/bdaf_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checker: remote channel stepping, filter pulse, bus reply
module bdaf_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_word,
    input wire logic        mem_ack,
    input wire logic        addr_accept,
    input wire logic        addr_done
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a finished access, split by width; a request still waiting
    sequence s_word_ack;
        mem_req && mem_ack && mem_word;
    endsequence
    sequence s_byte_ack;
        mem_req && mem_ack && !mem_word;
    endsequence
    sequence s_stall;
        mem_req && !mem_ack;
    endsequence
    AST_WORD_STEP:
        assert property (s_word_ack |=> mem_addr == $past(mem_addr) + 16'h0002)
        else $error("word access did not add two to the address");
    AST_BYTE_STEP:
        assert property (s_byte_ack |=> mem_addr == $past(mem_addr) + 16'h0001)
        else $error("byte access did not add one to the address");
    AST_ACK_DROP:
        assert property (mem_req && mem_ack |=> !mem_req ##1 $stable(mem_addr))
        else $error("request not dropped after an answered access");
    AST_STALL_HOLD:
        assert property (s_stall |=> mem_req && $stable(mem_addr))
        else $error("waiting request changed or vanished");
    AST_WORD_HELD:
        assert property (mem_req && $past(mem_req) |-> $stable(mem_word))
        else $error("access width changed within a transfer");
    AST_ADDR_QUIET:
        assert property (!mem_req && !$past(mem_req) |-> $stable(mem_addr))
        else $error("remote address moved while no access ran");
    AST_DONE_PULSE:
        assert property (addr_done |=> !addr_done [*8])
        else $error("destination done flag longer than one cycle");
    AST_VERDICT_HOLD:
        assert property (!addr_done && !$past(addr_done) |-> $stable(addr_accept))
        else $error("accept verdict changed away from a done pulse");
    AST_READ_BYTE:
        assert property (hrdata[31:8] == 24'h0 && hreadyout && !hresp)
        else $error("bus reply not a plain byte with okay status");
endmodule

bind bdaf_top bdaf_chk i_chk (
    .hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_word(mem_word), .mem_ack(mem_ack),
    .addr_accept(addr_accept), .addr_done(addr_done)
);
`default_nettype wire

// *** tb/bdaf_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// buffer memory stand-in: answers each access after some waits
module bdaf_mem_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    input  wire logic [3:0]  delay,
    output logic             mem_ack
);
    logic [15:0] addr_log [$];  // address of every answered access
    logic [3:0]  wait_q;        // waits spent on the current access
    // ack is one cycle long, so one request is never answered twice
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_ack <= 1'b0;
            wait_q  <= 4'h0;
        end else if (mem_req && !mem_ack && wait_q >= delay) begin
            mem_ack <= 1'b1;
            wait_q  <= 4'h0;
            addr_log.push_back(mem_addr);
        end else begin
            mem_ack <= 1'b0;
            wait_q  <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_bdaf_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bdaf_defs.svh"
// ============================================================
// bench: registers, remote channel, address filter, receive ring
module tb_bdaf_top;
    logic        hclk, hresetn = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic        rx_bit_valid = 1'b0, rx_bit = 1'b0, rx_frame = 1'b0;
    logic        rx_byte_stb = 1'b0, rx_error = 1'b0;
    logic        mem_req, mem_word, mem_ack, addr_accept, addr_done, local_abort;
    logic [15:0] mem_addr, exp_a;
    logic [3:0]  mem_delay = 4'h0;  // partner waits per access
    logic [47:0] sta, grp;          // station and group destinations
    logic [5:0]  h;                 // expected hash index
    int          miscompares = 0, tests_run = 0;

    bdaf_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_word(mem_word), .mem_ack(mem_ack),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_frame(rx_frame),
        .rx_byte_stb(rx_byte_stb), .rx_error(rx_error), .addr_accept(addr_accept),
        .addr_done(addr_done), .local_abort(local_abort)
    );
    bdaf_mem_model i_mem (
        .hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_addr(mem_addr),
        .delay(mem_delay), .mem_ack(mem_ack)
    );

    // ========================================================
    // clock and overall watchdog
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        #400000;
        miscompares++;
        final_report();
    end

    // ========================================================
    // verdict, compare, bus cycles
    task automatic final_report;
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h wanted %h", $time, got, exp);
        end
    endtask
    // bounded wait for the slave's ready
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            final_report();
        end
    endtask
    // one single transfer: address phase, then data phase
    task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask
    task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
        bus(idx, 1'b0, 8'h00);
        chk(rd, {24'h0, e});
    endtask
    // serial crc, msb first, over the destination in wire order
    function automatic logic [5:0] hash_of(input logic [47:0] da);
        logic [31:0] c;
        c = `BDAF_CRC_SEED;
        for (int i = 0; i < 48; i++)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? `BDAF_CRC_POLY : 32'h0);
        return c[31:26];
    endfunction
    // remote transfer; expectations derived from start, length and width
    task automatic remote(input logic [15:0] st, input logic [15:0] len, input logic w,
                          input logic [3:0] dly);
        int n, step;
        step = w ? 2 : 1;
        n = w ? (int'(len) + 1) / 2 : int'(len);
        mem_delay <= dly;
        i_mem.addr_log.delete();
        wr(`BDAF_IDX_RSTART_LO, st[7:0]);
        wr(`BDAF_IDX_RSTART_HI, st[15:8]);
        wr(`BDAF_IDX_RLEN_LO, len[7:0]);
        wr(`BDAF_IDX_RLEN_HI, len[15:8]);
        wr(`BDAF_IDX_CTRL, {6'h00, w, 1'b1});
        wr(`BDAF_IDX_CTRL, {6'h00, w, 1'b1});                // a start while busy is ignored
        rd = 32'h1;
        for (int k = 0; k < 100 && rd[0] !== 1'b0; k++) bus(`BDAF_IDX_STATUS, 1'b0, 8'h00);
        repeat (10) @(posedge hclk);
        chk(32'(rd[0]), 32'h0);
        chk(32'(i_mem.addr_log.size()), 32'(n));
        for (int k = 0; k < n && k < i_mem.addr_log.size(); k++)
            chk(32'(i_mem.addr_log[k]), 32'(st + 16'(k * step)));
        exp_a = st + 16'(n * step);
        if (n > 0) begin
            rchk(`BDAF_IDX_RPTR_LO, exp_a[7:0]);
            rchk(`BDAF_IDX_RPTR_HI, exp_a[15:8]);
        end
    endtask
    // one destination on the serial path, first bit da[0]; done must come once
    task automatic send_da(input logic [47:0] da, input logic acc, input logic grp_f);
        int dones;
        dones = 0;
        rx_frame <= 1'b1;
        repeat (4) @(posedge hclk);
        for (int i = 0; i < 54; i++) begin
            if (i < 48) rx_bit <= da[i];
            rx_bit_valid <= (i < 48);
            for (int k = 0; k < 4; k++) begin
                @(posedge hclk);
                if (k == 1) rx_bit_valid <= 1'b0;
                if (addr_done === 1'b1) dones += (i < 47) ? 9 : 1;
            end
        end
        chk(32'(dones), 32'h1);
        chk(32'(addr_accept), 32'(acc));
        rx_frame <= 1'b0;
        rx_bit <= ~rx_bit;                                   // no stale bit left after a frame
        bus(`BDAF_IDX_STATUS, 1'b0, 8'h00);
        chk(32'(rd[4]), 32'(grp_f));
    endtask
    task automatic strobes(input int cnt);
        repeat (cnt) begin
            rx_byte_stb <= 1'b1;
            repeat (2) @(posedge hclk);
            rx_byte_stb <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
    endtask

    // ========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // plain registers: reset value, then a pattern read back
        for (int i = 0; i < 32; i++) begin
            if (!(i inside {[6:7], [12:15], [22:23]})) begin
                rchk(6'(i), 8'h00);
                wr(6'(i), 8'(i * 37 + 5));
                rchk(6'(i), 8'(i * 37 + 5));
            end
        end
        wr(`BDAF_IDX_TXLEN_LO, 8'hFF);
        wr(`BDAF_IDX_TXLEN_HI, 8'hFF);
        rchk(`BDAF_IDX_TXLEN_HI, 8'hFF);
        wr(`BDAF_IDX_LOCAL_HI, 8'hA5);
        rchk(`BDAF_IDX_LOCAL_HI, 8'h00);
        wr(6'h3F, 8'hA5);
        rchk(6'h3F, 8'h00);
        // remote channel: odd word count across a page, bytes, zero length
        remote(16'h12FE, 16'h0005, 1'b1, 4'h2);
        remote(16'h00FF, 16'h0003, 1'b0, 4'h0);
        remote(16'h8000, 16'h0000, 1'b1, 4'h1);
        // destination filter
        sta = 48'hA1B2_C3D4_E5F6;
        grp = 48'h1234_5678_9A01;
        h = hash_of(grp);
        for (int k = 0; k < 8; k++) begin
            if (k < 6) wr(`BDAF_IDX_STATION0 + 6'(k), sta[8 * k +: 8]);
            wr(`BDAF_IDX_HASH0 + 6'(k), 8'h00);
        end
        send_da(sta, 1'b1, 1'b0);
        send_da(sta ^ 48'h8000_0000_0000, 1'b0, 1'b0);
        send_da(grp, 1'b0, 1'b1);
        wr(`BDAF_IDX_HASH0 + 6'(h[5:3]), 8'h01 << h[2:0]);
        send_da(grp, 1'b1, 1'b1);
        for (int k = 0; k < 8; k++) wr(`BDAF_IDX_HASH0 + 6'(k), 8'hFF);
        wr(`BDAF_IDX_HASH0 + 6'(h[5:3]), ~(8'h01 << h[2:0]));
        send_da(grp, 1'b0, 1'b1);
        wr(`BDAF_IDX_HASH0 + 6'(h[5:3]), 8'hFF);
        send_da(48'hFFFF_FFFF_FFFF, 1'b1, 1'b1);
        wr(`BDAF_IDX_CTRL, 8'h08);
        send_da(sta ^ 48'h0100, 1'b1, 1'b0);
        wr(`BDAF_IDX_CTRL, 8'h00);
        // second reset so the write page is set only once after it
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(`BDAF_IDX_RX_WRPAGE, 8'h00);
        wr(`BDAF_IDX_RING_FIRST, 8'h40);
        wr(`BDAF_IDX_RING_END, 8'h42);
        wr(`BDAF_IDX_RING_BNDRY, 8'h43);
        wr(`BDAF_IDX_RX_WRPAGE, 8'h41);
        wr(`BDAF_IDX_CTRL, 8'h04);
        strobes(256);
        rchk(`BDAF_IDX_LOCAL_LO, 8'h00);
        rchk(`BDAF_IDX_LOCAL_HI, 8'h40);
        strobes(3);
        rchk(`BDAF_IDX_LOCAL_LO, 8'h03);
        rx_error <= 1'b1;
        repeat (4) @(posedge hclk);
        rx_error <= 1'b0;
        repeat (6) @(posedge hclk);
        rchk(`BDAF_IDX_LOCAL_HI, 8'h41);
        rchk(`BDAF_IDX_LOCAL_LO, 8'h00);
        chk(32'(local_abort), 32'h0);
        wr(`BDAF_IDX_RING_BNDRY, 8'h40);
        strobes(256);
        chk(32'(local_abort), 32'h1);
        final_report();
    end
endmodule
`default_nettype wire
